// ---- src/tprm_params.svh ----
// Offsets, field positions, codes and timing for the parameter report block
`ifndef TPRM_PARAMS_SVH
`define TPRM_PARAMS_SVH

// Register byte offsets
`define TPRM_OFS_CTRL 8'h00
`define TPRM_OFS_LINECFG 8'h04
`define TPRM_OFS_MODE 8'h08
`define TPRM_OFS_MARGIN 8'h0C
`define TPRM_OFS_CURSOR 8'h10
`define TPRM_OFS_SAVED 8'h14
`define TPRM_OFS_WIDTH 8'h18

// Field positions
`define TPRM_CTRL_SETUP 0
`define TPRM_LCFG_PAR_EN 0
`define TPRM_LCFG_PAR_ODD 1
`define TPRM_LCFG_BITS8 2
`define TPRM_LCFG_XSPD 4
`define TPRM_LCFG_RSPD 8
`define TPRM_LCFG_FLAGS 12

// Reset values
`define TPRM_CTRL_RST 32'h0000_0000
`define TPRM_LCFG_RST 32'h0000_0000

// Characters
`define TPRM_CH_ESC 8'h1B
`define TPRM_CH_CSI 8'h5B
`define TPRM_CH_HASH 8'h23
`define TPRM_CH_SEMI 8'h3B
`define TPRM_CH_PRIV 8'h3F
`define TPRM_CH_ZERO 8'h30
`define TPRM_CH_NINE 8'h39
`define TPRM_CH_SAVE 8'h37
`define TPRM_CH_REQ 8'h78
`define TPRM_CH_MARG 8'h72
`define TPRM_CH_SETM 8'h68
`define TPRM_CH_RSTM 8'h6C
`define TPRM_CH_SWL 8'h35
`define TPRM_CH_DHT 8'h33
`define TPRM_CH_DHB 8'h34
`define TPRM_CH_DWL 8'h36
`define TPRM_CH_FINLO 8'h40
`define TPRM_CH_FINHI 8'h7E

// Report codes
`define TPRM_SOL_UNSOL 8'h02
`define TPRM_SOL_ONREQ 8'h03
`define TPRM_PAR_NONE 8'h01
`define TPRM_PAR_ODD 8'h04
`define TPRM_PAR_EVEN 8'h05
`define TPRM_NB_8 8'h01
`define TPRM_NB_7 8'h02
`define TPRM_CLKMUL 8'h01

// Private mode numbers
`define TPRM_MODE_SMOOTH 8'h04
`define TPRM_MODE_REVERSE 8'h05
`define TPRM_MODE_ORIGIN 8'h06

// Timing
`define TPRM_CLK_HZ 250000000
`define TPRM_SMOOTH_LPS 6
`define TPRM_SMOOTH_CYC \
    ((`TPRM_CLK_HZ + `TPRM_SMOOTH_LPS - 1) / `TPRM_SMOOTH_LPS)

`endif

// ---- src/tprm_pkg.sv ----
// Types shared by the parameter report block
package tprm_pkg;
    typedef enum logic [1:0] {P_IDLE, P_ESC, P_CSI, P_HASH} tprm_parse_e;
    typedef enum logic [2:0] {
        R_IDLE, R_ESC, R_BRK, R_DIG, R_SEP, R_DONE
    } tprm_rpt_e;
    typedef logic [7:0] tprm_byte_t;
    typedef tprm_byte_t [6:0] tprm_fields_t;
endpackage

// ---- src/tprm_report_if.sv ----
// Start, busy and field values between interpreter and report sender
`timescale 1ns/1ps
interface tprm_report_if;
    logic start;
    logic busy;
    tprm_pkg::tprm_fields_t fields;
    modport src (output start, output fields, input busy);
    modport gen (input start, input fields, output busy);
endinterface

// ---- src/tprm_report_gen.sv ----
// Serialises one parameter report as decimal text bytes
`timescale 1ns/1ps
module tprm_report_gen (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Request side
    tprm_report_if.gen rpt,
    // Byte stream to the host
    output logic tx_valid,
    output tprm_pkg::tprm_byte_t tx_data,
    input wire logic tx_ready
);
    import tprm_pkg::*;
    `include "tprm_params.svh"

    tprm_rpt_e state;
    tprm_fields_t fld;
    logic [2:0] fi;
    logic [1:0] dsel;
    logic busy;

    function automatic logic [1:0] first_dig(input tprm_byte_t v);
        first_dig = (v >= 8'd100) ? 2'd0 : ((v >= 8'd10) ? 2'd1 : 2'd2);
    endfunction

    function automatic tprm_byte_t dig_char(input tprm_byte_t v,
                                            input logic [1:0] d);
        tprm_byte_t r;
        r = (d == 2'd0) ? v / 8'd100 :
            ((d == 2'd1) ? (v / 8'd10) % 8'd10 : v % 8'd10);
        dig_char = r + `TPRM_CH_ZERO;
    endfunction

    wire adv = !tx_valid || tx_ready;
    wire last_fld = (fi == 3'd6);
    wire [2:0] fi_nxt = fi + 3'd1;
    wire tprm_byte_t cur_v = fld[fi];
    wire tprm_byte_t nxt_v = fld[fi_nxt];

    assign rpt.busy = busy;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= R_IDLE;
            fld <= '0;
            fi <= 3'd0;
            dsel <= 2'd0;
            busy <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            case (state)
                R_IDLE: begin
                    if (rpt.start) begin
                        fld <= rpt.fields;
                        busy <= 1'b1;
                        state <= R_ESC;
                    end
                end
                R_ESC: begin
                    if (adv) begin
                        tx_valid <= 1'b1;
                        tx_data <= `TPRM_CH_ESC;
                        state <= R_BRK;
                    end
                end
                R_BRK: begin
                    if (adv) begin
                        tx_data <= `TPRM_CH_CSI;
                        fi <= 3'd0;
                        dsel <= first_dig(fld[0]);
                        state <= R_DIG;
                    end
                end
                R_DIG: begin
                    if (adv) begin
                        tx_data <= dig_char(cur_v, dsel);
                        dsel <= dsel + 2'd1;
                        if (dsel == 2'd2) begin
                            state <= R_SEP;
                        end
                    end
                end
                R_SEP: begin
                    if (adv) begin
                        tx_data <= last_fld ? `TPRM_CH_REQ : `TPRM_CH_SEMI;
                        if (last_fld) begin
                            state <= R_DONE;
                        end else begin
                            fi <= fi_nxt;
                            dsel <= first_dig(nxt_v);
                            state <= R_DIG;
                        end
                    end
                end
                R_DONE: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        busy <= 1'b0;
                        state <= R_IDLE;
                    end
                end
                default: begin
                    state <= R_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- src/tprm_top.sv ----
// Escape interpreter: parameter reports, margins, modes, cursor save
`timescale 1ns/1ps
`include "tprm_params.svh"
// Summary of operation
// - Request with code zero or none also allows unsolicited reports.
// - With unsolicited allowed, report whenever setup mode is left.
// - Request with code 1 limits reports to answers on request.
// - Reports carry code 2 when unsolicited allowed, else code 3.
// - Parity field: 1 none, 4 odd, 5 even.
// - Length field: 1 for eight bits, 2 for seven bits.
// - Multiplier field is 1; speeds are codes 0 to 120 by eight.
// - Every parameter request with code 0, 1 or none is answered with one report.
// - After reset no unsolicited reports until a request with code zero or none.
// - Cursor save stores position, attributes and character set.
// - Jump scroll when reset; smooth at most six lines per second set.
// - Polarity reset white on black; set black on white.
// - Margin sequence: first top, second bottom; missing means full screen.
// - Scroll region at least two lines: top below bottom.
// - Accepted new margins send the cursor home.
// - Single width sequence makes cursor line normal; cursor stays.
// - Every newly created line starts single width and height.
// - Home is top left of screen, or of margins in origin mode.
module tprm_top #(
    parameter int ROWS = 24,
    parameter int SMOOTH_CYC = `TPRM_SMOOTH_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // AXI4-Lite register slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Bytes received from the host
    input wire tprm_pkg::tprm_byte_t rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    // Bytes sent to the host
    output tprm_pkg::tprm_byte_t tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Display state from and to the rest of the terminal
    input wire logic [3:0] char_attr,
    input wire logic [1:0] char_set,
    input wire logic scroll_req,
    input wire logic line_new,
    input wire logic [7:0] line_new_row,
    output logic scroll_go,
    output logic smooth_scroll,
    output logic screen_reverse,
    output logic origin_mode,
    output logic [7:0] cursor_row,
    output logic [7:0] cursor_col
);
    import tprm_pkg::*;

    localparam logic [7:0] ROWS_B = 8'(ROWS);
    localparam logic [31:0] GAP_RELOAD = 32'(SMOOTH_CYC - 1);
    logic [1:0] rst_sync;
    wire rst_n = rst_sync[1];
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
        end
        merge = old;
    endfunction

    // AXI4-Lite slave
    logic aw_full, w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] ctrl, linecfg;
    logic [ROWS-1:0] dwidth;
    logic [7:0] top_m, bot_m, sv_row, sv_col;
    logic [3:0] sv_attr;
    logic [1:0] sv_set;
    logic unsol_en;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire do_wr = aw_full && w_full && !s_axi_bvalid;
    wire next_aw_full = (aw_full && !do_wr) || aw_take;
    wire next_w_full = (w_full && !do_wr) || w_take;
    wire next_bvalid = (s_axi_bvalid && !s_axi_bready) || do_wr;
    wire next_rvalid = (s_axi_rvalid && !s_axi_rready) || ar_take;
    wire wr_ctrl = do_wr && aw_addr == `TPRM_OFS_CTRL;
    wire wr_lcfg = do_wr && aw_addr == `TPRM_OFS_LINECFG;
    wire wr_curs = do_wr && aw_addr == `TPRM_OFS_CURSOR;
    wire wr_ro = aw_addr == `TPRM_OFS_MODE || aw_addr == `TPRM_OFS_MARGIN ||
                 aw_addr == `TPRM_OFS_SAVED || aw_addr == `TPRM_OFS_WIDTH;
    wire wr_ok = wr_ctrl || wr_lcfg || wr_curs || wr_ro;
    wire [31:0] curs_word = {16'h0000, cursor_col, cursor_row};
    wire [31:0] curs_new = merge(curs_word, w_data, w_strb);
    wire [31:0] mode_word = {28'h0000000, unsol_en, origin_mode,
                             screen_reverse, smooth_scroll};
    wire [31:0] rd_mux =
        s_axi_araddr == `TPRM_OFS_CTRL ? ctrl :
        s_axi_araddr == `TPRM_OFS_LINECFG ? linecfg :
        s_axi_araddr == `TPRM_OFS_MODE ? mode_word :
        s_axi_araddr == `TPRM_OFS_MARGIN ? {16'h0000, bot_m, top_m} :
        s_axi_araddr == `TPRM_OFS_CURSOR ? curs_word :
        s_axi_araddr == `TPRM_OFS_SAVED ?
            {10'h000, sv_set, sv_attr, sv_col, sv_row} :
        s_axi_araddr == `TPRM_OFS_WIDTH ? 32'(dwidth) : 32'h0000_0000;
    wire rd_ok = rd_mux != 32'h0 || s_axi_araddr <= `TPRM_OFS_WIDTH &&
                 s_axi_araddr[1:0] == 2'b00;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {aw_full, w_full, s_axi_bvalid, s_axi_rvalid} <= 4'h0;
            {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'b111;
            {aw_addr, w_data, w_strb} <= '0;
            {s_axi_bresp, s_axi_rresp, s_axi_rdata} <= '0;
            ctrl <= `TPRM_CTRL_RST;
            linecfg <= `TPRM_LCFG_RST;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            s_axi_bvalid <= next_bvalid;
            s_axi_rvalid <= next_rvalid;
            s_axi_awready <= !next_aw_full && !next_bvalid;
            s_axi_wready <= !next_w_full && !next_bvalid;
            s_axi_arready <= !next_rvalid;
            if (aw_take) aw_addr <= s_axi_awaddr;
            if (w_take) {w_data, w_strb} <= {s_axi_wdata, s_axi_wstrb};
            if (do_wr) s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            if (ar_take) begin
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            end
            if (wr_ctrl) ctrl <= merge(ctrl, w_data, w_strb);
            if (wr_lcfg) linecfg <= merge(linecfg, w_data, w_strb);
        end
    end

    // Escape sequence parser
    tprm_parse_e pst;
    logic [7:0] p0, p1;
    logic have0, have1, priv, pidx, pover;

    function automatic logic [7:0] acc(input logic [7:0] p,
                                       input logic [7:0] ch);
        logic [15:0] s;
        s = 16'(p) * 16'd10 + 16'(ch - `TPRM_CH_ZERO);
        acc = (s > 16'd255) ? 8'hFF : s[7:0];
    endfunction

    function automatic logic mode_hit(input logic [7:0] a, input logic ha,
                                      input logic [7:0] b, input logic hb,
                                      input logic [7:0] n);
        mode_hit = (ha && a == n) || (hb && b == n);
    endfunction

    wire rx_take = rx_valid && rx_ready;
    wire is_dig = rx_data >= `TPRM_CH_ZERO && rx_data <= `TPRM_CH_NINE;
    wire is_fin = rx_data >= `TPRM_CH_FINLO && rx_data <= `TPRM_CH_FINHI;
    wire csi_fin = rx_take && pst == P_CSI && is_fin;
    wire [7:0] sol = have0 ? p0 : 8'h00;
    wire req_x = csi_fin && !priv && rx_data == `TPRM_CH_REQ &&
                 sol <= 8'h01;
    wire do_marg = csi_fin && !priv && rx_data == `TPRM_CH_MARG;
    wire m_set = csi_fin && priv && rx_data == `TPRM_CH_SETM;
    wire m_clr = csi_fin && priv && rx_data == `TPRM_CH_RSTM;
    wire m_any = m_set || m_clr;
    wire hit_sm = mode_hit(p0, have0, p1, have1, `TPRM_MODE_SMOOTH);
    wire hit_rv = mode_hit(p0, have0, p1, have1, `TPRM_MODE_REVERSE);
    wire hit_or = mode_hit(p0, have0, p1, have1, `TPRM_MODE_ORIGIN);
    wire do_save = rx_take && pst == P_ESC && rx_data == `TPRM_CH_SAVE;
    wire in_hash = rx_take && pst == P_HASH;
    wire do_swl = in_hash && rx_data == `TPRM_CH_SWL;
    wire do_dwl = in_hash && (rx_data == `TPRM_CH_DHT ||
                  rx_data == `TPRM_CH_DHB || rx_data == `TPRM_CH_DWL);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pst <= P_IDLE;
            {p0, p1, have0, have1, priv, pidx, pover} <= '0;
        end else if (rx_take) begin
            case (pst)
                P_IDLE: pst <= (rx_data == `TPRM_CH_ESC) ? P_ESC : P_IDLE;
                P_ESC: begin
                    {p0, p1, have0, have1, priv, pidx, pover} <= '0;
                    pst <= rx_data == `TPRM_CH_CSI ? P_CSI :
                           rx_data == `TPRM_CH_HASH ? P_HASH :
                           rx_data == `TPRM_CH_ESC ? P_ESC : P_IDLE;
                end
                P_CSI: begin
                    if (rx_data == `TPRM_CH_ESC || is_fin) begin
                        pst <= rx_data == `TPRM_CH_ESC ? P_ESC : P_IDLE;
                    end else if (rx_data == `TPRM_CH_PRIV) begin
                        priv <= 1'b1;
                    end else if (rx_data == `TPRM_CH_SEMI) begin
                        pover <= pidx;
                        pidx <= 1'b1;
                    end else if (is_dig && !pover && !pidx) begin
                        p0 <= acc(p0, rx_data);
                        have0 <= 1'b1;
                    end else if (is_dig && !pover) begin
                        p1 <= acc(p1, rx_data);
                        have1 <= 1'b1;
                    end
                end
                P_HASH: pst <= (rx_data == `TPRM_CH_ESC) ? P_ESC : P_IDLE;
                default: pst <= P_IDLE;
            endcase
        end
    end

    // Margins, modes and cursor
    wire [7:0] top_v = (have0 && p0 != 8'h00) ? p0 : 8'h01;
    wire [7:0] bot_v = (have1 && p1 != 8'h00) ? p1 : ROWS_B;
    wire marg_ok = top_v < bot_v && bot_v <= ROWS_B;
    wire next_origin = m_any && hit_or ? m_set : origin_mode;
    wire [7:0] next_top = do_marg && marg_ok ? top_v : top_m;
    wire go_home = (do_marg && marg_ok) || (m_any && hit_or);
    wire [7:0] home_row = next_origin ? next_top : 8'h01;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {smooth_scroll, screen_reverse, origin_mode} <= 3'b000;
            top_m <= 8'h01;
            bot_m <= ROWS_B;
            cursor_row <= 8'h01;
            cursor_col <= 8'h01;
            {sv_row, sv_col, sv_attr, sv_set} <= {8'h01, 8'h01, 6'h00};
        end else begin
            if (m_any && hit_sm) smooth_scroll <= m_set;
            if (m_any && hit_rv) screen_reverse <= m_set;
            origin_mode <= next_origin;
            if (do_marg && marg_ok) begin
                top_m <= top_v;
                bot_m <= bot_v;
            end
            if (go_home) begin
                cursor_row <= home_row;
                cursor_col <= 8'h01;
            end else if (wr_curs) begin
                cursor_row <= curs_new[7:0];
                cursor_col <= curs_new[15:8];
            end
            if (do_save) begin
                sv_row <= cursor_row;
                sv_col <= cursor_col;
                sv_attr <= char_attr;
                sv_set <= char_set;
            end
        end
    end

    // Line width flags; cursor is left where it is
    genvar gi;
    generate
        for (gi = 0; gi < ROWS; gi++) begin : g_line
            wire at_cur = cursor_row == 8'(gi + 1);
            wire fresh = line_new && line_new_row == 8'(gi + 1);
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    dwidth[gi] <= 1'b0;
                end else if (fresh || (do_swl && at_cur)) begin
                    dwidth[gi] <= 1'b0;
                end else if (do_dwl && at_cur) begin
                    dwidth[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Scroll pacing
    logic scroll_wait;
    logic [31:0] gap;
    wire next_go = scroll_wait && (!smooth_scroll || gap == 32'h0);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {scroll_wait, scroll_go} <= 2'b00;
            gap <= 32'h0;
        end else begin
            scroll_go <= next_go;
            scroll_wait <= scroll_req || (scroll_wait && !next_go);
            if (next_go) begin
                gap <= GAP_RELOAD;
            end else if (gap != 32'h0) begin
                gap <= gap - 32'h1;
            end
        end
    end

    // Report requests
    tprm_report_if rpt ();
    logic req_pend, unsol_pend, setup_prev;
    wire setup_now = ctrl[`TPRM_CTRL_SETUP];
    wire setup_exit = setup_prev && !setup_now;
    wire start_req = req_pend && !rpt.busy;
    wire start_uns = unsol_pend && !req_pend && !rpt.busy;
    wire next_rx_ready = !(req_pend || rpt.busy) && !req_x;

    assign rpt.start = start_req || start_uns;
    assign rpt.fields = {
        linecfg[`TPRM_LCFG_FLAGS +: 4] & 8'h0F,
        `TPRM_CLKMUL,
        {1'b0, linecfg[`TPRM_LCFG_RSPD +: 4], 3'b000},
        {1'b0, linecfg[`TPRM_LCFG_XSPD +: 4], 3'b000},
        linecfg[`TPRM_LCFG_BITS8] ? `TPRM_NB_8 : `TPRM_NB_7,
        !linecfg[`TPRM_LCFG_PAR_EN] ? `TPRM_PAR_NONE :
            linecfg[`TPRM_LCFG_PAR_ODD] ? `TPRM_PAR_ODD : `TPRM_PAR_EVEN,
        (start_uns || unsol_en) ? `TPRM_SOL_UNSOL : `TPRM_SOL_ONREQ
    };

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {req_pend, unsol_pend, unsol_en, setup_prev} <= 4'h0;
            rx_ready <= 1'b0;
        end else begin
            setup_prev <= setup_now;
            rx_ready <= next_rx_ready;
            if (req_x) unsol_en <= (sol == 8'h00);
            req_pend <= req_x || (req_pend && !start_req);
            unsol_pend <= (setup_exit && unsol_en) ||
                          (unsol_pend && !start_uns && unsol_en);
        end
    end

    tprm_report_gen u_gen (
        .clock(clock),
        .rst_n(rst_n),
        .rpt(rpt),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready)
    );
endmodule

// ---- tb/tprm_host_model.sv ----
// Host model: takes report bytes with random stalls
`timescale 1ns/1ps
module tprm_host_model (
    // Clock
    input wire logic clock,
    // Report bytes from the device
    input wire tprm_pkg::tprm_byte_t tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // Byte taken, seen one cycle later
    output logic got,
    output tprm_pkg::tprm_byte_t got_data
);
    import tprm_pkg::*;
    initial tx_ready = 1'b0;
    initial got = 1'b0;
    always @(posedge clock) begin
        got <= tx_valid && tx_ready;
        got_data <= tx_data;
        tx_ready <= ($urandom % 3) != 0;
    end
endmodule

// ---- tb/tprm_top_assertions.sv ----
// Port-level checker for the parameter report block
`timescale 1ns/1ps
module tprm_top_assertions (
    // Clock and reset
    input wire logic clock, rstn,
    // Register bus handshakes
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid,
    // Host byte links
    input wire logic rx_ready, tx_valid, tx_ready,
    input wire tprm_pkg::tprm_byte_t tx_data,
    // Display state
    input wire logic scroll_req, scroll_go, smooth_scroll, origin_mode,
    input wire logic [7:0] cursor_col
);
    import tprm_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    jump_scroll_a: assert property (scroll_req && !smooth_scroll
        ##1 !smooth_scroll |=> scroll_go) else $error("no jump");
    smooth_gap_a: assert property (smooth_scroll && scroll_go |=>
        (!scroll_go || !smooth_scroll) [*8]) else $error("smooth too fast");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid
        && $stable(tx_data)) else $error("report byte dropped");
    rx_block_a: assert property (tx_valid |-> !rx_ready)
        else $error("bytes taken while reporting");
    report_start_a: assert property ($rose(tx_valid) |->
        tx_data == 8'h1B) else $error("report does not start with escape");
    write_resp_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    resp_busy_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready during resp");
    origin_home_a: assert property ($changed(origin_mode) |->
        cursor_col == 8'h01) else $error("cursor not homed");
    cover property (smooth_scroll && scroll_go);
    cover property (tx_valid && !tx_ready);
    cover property ($rose(origin_mode));
endmodule
bind tprm_top tprm_top_assertions i_tprm_top_assertions (.*);

// ---- tb/testbench.sv ----
// Self-checking bench for the parameter report block
`timescale 1ns/1ps
module testbench;
    import tprm_pkg::*;
    logic clock = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, rx_valid = 1'b0, scroll_req = 1'b0;
    logic line_new = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, rx_ready, tx_valid, tx_ready, got;
    logic scroll_go, smooth_scroll, screen_reverse, origin_mode;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, line_new_row = '0;
    logic [7:0] cursor_row, cursor_col;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, lc;
    logic [3:0] s_axi_wstrb = 4'hF, char_attr = '0;
    logic [1:0] char_set = '0, s_axi_bresp, s_axi_rresp;
    tprm_byte_t rx_data = '0, tx_data, got_data, q[$];
    int fail_count = 0, cmp_count = 0, cyc = 0, sols[4] = '{3, 2, 3, 2};
    string reqs[4] = '{"\033[1x", "\033[x", "\033[1x", "\033[0x"};
    tprm_top #(.SMOOTH_CYC(20)) i_tprm_top (.*);
    tprm_host_model i_tprm_host_model (.*);
    always #2 clock = ~clock;
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (q.size() != 0) fail_count++;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        bit ta, tw;
        @(posedge clock);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ta && tw)) begin
            @(posedge clock);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        do @(posedge clock); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r, "bresp");
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata[29:0]}, {r, e[29:0]}, "read");
    endtask
    task automatic snd(input string s);
        foreach (s[k]) begin
            @(posedge clock);
            {rx_data, rx_valid} <= {s[k], 1'b1};
            do @(posedge clock); while (rx_ready !== 1'b1);
            {rx_data, rx_valid} <= {~s[k], 1'b0};
        end
        repeat (2) @(posedge clock);
    endtask
    task automatic exp_rpt(input int sol);
        string s;
        s = $sformatf("\033[%0d;%0d;%0d;%0d;%0d;1;%0dx", sol,
            lc[0] ? (lc[1] ? 4 : 5) : 1, lc[2] ? 1 : 2,
            lc[7:4] * 8, lc[11:8] * 8, lc[15:12]);
        foreach (s[k]) q.push_back(s[k]);
    endtask
    task automatic drain();
        while (q.size() != 0) @(posedge clock);
        repeat (40) @(posedge clock);
    endtask
    always @(posedge clock) begin
        cyc++;
        scroll_req <= (cyc % 7 == 0);
        if (cyc == 30000) fail_count++;
        if (cyc == 30000) finish_test();
        if (got === 1'b1 && q.size() == 0) chk(1, 0, "tx_extra");
        else if (got === 1'b1) chk(got_data, q.pop_front(), "tx");
    end
    initial begin
        void'($urandom(32'hDA68));
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        axr(8'h08, '0, 2'h0);
        axr(8'h1C, '0, 2'h2);
        axw(8'h1C, '0, 2'h2);
        axw(8'h00, 32'h1, 2'h0);
        axw(8'h00, '0, 2'h0);
        drain();
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            lc = {16'h0, 16'($urandom) & 16'hFFF7};
            axw(8'h04, lc, 2'h0);
            exp_rpt(sols[i]);
            snd(reqs[i]);
            drain();
            axw(8'h00, 32'h1, 2'h0);
            if (sols[i] == 2) exp_rpt(2);
            axw(8'h00, '0, 2'h0);
            drain();
        end
        $display("test reports done");
        for (int m = 4; m < 7; m++) begin
            snd($sformatf("\033[?%0dh", m));
            chk({origin_mode, screen_reverse, smooth_scroll},
                (1 << (m - 3)) - 1, "modes");
        end
        repeat (80) @(posedge clock);
        snd("\033[?4;5l");
        snd("\033[?6l");
        chk({origin_mode, screen_reverse, smooth_scroll}, 0, "modes");
        axw(8'h10, 32'h0000_0703, 2'h0);
        snd("\033[5;10r");
        axr(8'h0C, 32'h0000_0A05, 2'h0);
        chk({cursor_row, cursor_col}, 16'h0101, "home");
        axw(8'h10, 32'h0000_0703, 2'h0);
        snd("\033[10;5r");
        snd("\033[5;30r");
        axr(8'h0C, 32'h0000_0A05, 2'h0);
        chk({cursor_row, cursor_col}, 16'h0307, "cursor");
        snd("\033[?6h");
        chk(cursor_row, 8'h05, "home");
        snd("\033[?6l");
        snd("\033[r");
        axr(8'h0C, 32'h0000_1801, 2'h0);
        {char_attr, char_set} <= 6'($urandom);
        axw(8'h10, 32'h0000_0C04, 2'h0);
        snd("\0337");
        axr(8'h14, {10'h0, char_set, char_attr, 16'h0C04}, 2'h0);
        snd("\033#6");
        axr(8'h18, 32'h0000_0008, 2'h0);
        snd("\033#5");
        axr(8'h18, '0, 2'h0);
        chk(cursor_col, 8'h0C, "column");
        snd("\033#6");
        {line_new_row, line_new} <= 9'h009;
        @(posedge clock);
        line_new <= 1'b0;
        axr(8'h18, '0, 2'h0);
        $display("test display done");
        finish_test();
    end
endmodule
